// file: rtl/buck_startup_seq.sv
/*
 * start-up and protection sequencer of a synchronous buck controller, with an
 * axi4-lite register slave. assumes comparator outputs arrive asynchronously
 * on pins and the external power stage follows the two gate enables.
 */
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - stay off and ignore enable until supply power-on detect is high
// - compensation variant starts soft-start once enable pin is above threshold
// - compensation variant: pin charging source stays on until pin above ceiling in normal run, off in reference variant
// - reference variant waits delay, then picks internal or external reference
// - reference variant starts soft-start only after reference selection
// - regulation target is the lower of reference and ramp
// - ramp is one hundred equal steps up to the reference
// - ramp time to reference depends on the speed variant
// - ramp continues to ceiling, then soft-start done and undervoltage armed
// - with external reference, ramp time scales with reference voltage
// - output below target: gates off until ramp exceeds output
// - output above target: gates off until output falls to target
// - first high-side turn-on checks switch node, else input absent abort
// - after input absent, ramp runs to top, then a new attempt
// - overcurrent drives both gates low and restarts by hiccup
// - overcurrent after fourth retry latches off with both gates low
// - overvoltage drives low side on and high side off
// - overvoltage is watched only in the reference-delay, ramp, run and hiccup states, not in off, idle or latched-off
// - overvoltage does not latch; regulation resumes when it clears
// - undervoltage trips only after comparator held for qualification delay
// - undervoltage drives gates low and retries forever
module buck_startup_seq #(
	parameter int REF_DELAY = buck_seq_pkg::REF_DELAY_CYC,
	parameter int HICCUP    = buck_seq_pkg::HICCUP_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        por_ok_i,
	input  wire logic        enable_above_i,
	input  wire logic        comp_ceiling_i,
	input  wire logic        reference_enable_pin_high_i,
	input  wire logic        phase_high_i,
	input  wire logic        overcurrent_i,
	input  wire logic        overvoltage_i,
	input  wire logic        undervoltage_i,
	input  wire logic        ramp_above_out_i,
	input  wire logic        out_above_target_i,
	input  wire logic        pwm_high_i,
	output logic             high_side_drive_o,
	output logic             low_side_drive_o,
	output logic             charge_src_en_o,
	output logic             ref_ext_sel_o,
	output logic [9:0]       ss_code_o,
	output logic [9:0]       target_code_o,
	output logic             ss_done_o,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	localparam logic [15:0] REF_DELAY_W = 16'(REF_DELAY);
	localparam logic [15:0] HICCUP_W    = 16'(HICCUP);

	// ext ramp: tss(ms) = 2.5 * vref(V), per-step cycles = mv * 5 / 8
	function automatic logic [15:0] ext_step(input logic [11:0] mv);
		logic [31:0] c;
		c = (32'(mv) * 32'(buck_seq_pkg::EXT_FACTOR_X10) * 32'h0000_03E8)
			/ (32'h0000_000A * 32'(buck_seq_pkg::CLK_NS) * 32'(buck_seq_pkg::SS_STEPS));
		ext_step = (c == 32'h0) ? 16'h0001 : c[15:0];
	endfunction : ext_step

	// --------------------------------
	// pin synchronisers
	// --------------------------------
	logic [10:0] sync1_q;
	logic [10:0] sync2_q;
	logic        por_s, en_s, comp_ceil_s, reference_enable_pin_s, phase_s, oc_s, ov_s, uv_s;
	logic        above_out_s, out_high_s, pwm_s;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_q <= 11'h000;
			sync2_q <= 11'h000;
		end
		else
		begin
			sync1_q <= {por_ok_i, enable_above_i, comp_ceiling_i, reference_enable_pin_high_i,
				phase_high_i, overcurrent_i, overvoltage_i, undervoltage_i,
				ramp_above_out_i, out_above_target_i, pwm_high_i};
			sync2_q <= sync1_q;
		end
	end

	assign {por_s, en_s, comp_ceil_s, reference_enable_pin_s, phase_s, oc_s, ov_s, uv_s,
		above_out_s, out_high_s, pwm_s} = sync2_q;

	// --------------------------------
	// registers
	// --------------------------------
	logic [2:0]  ctrl_q;
	logic [11:0] extref_q;
	logic        aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic        ref_variant;
	buck_seq_pkg::speed_t speed;
	buck_seq_pkg::state_t state_q;
	logic        absent_q, latch_q, ss_done_q, uv_trip_q;
	logic [2:0]  retry_q;

	assign ref_variant = ctrl_q[0];
	assign speed       = buck_seq_pkg::speed_t'(ctrl_q[2:1]);

	// --------------------------------
	// axi4-lite write path
	// --------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= buck_seq_pkg::RESP_OKAY;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			ctrl_q    <= buck_seq_pkg::CTRL_RST;
			extref_q  <= buck_seq_pkg::EXTREF_RST;
		end
		else
		begin
			awready_q <= s_axi_awvalid && !awready_q && !aw_have_q && !bvalid_q;
			wready_q  <= s_axi_wvalid && !wready_q && !w_have_q && !bvalid_q;
			if (s_axi_awvalid && awready_q)
			begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q)
			begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (aw_have_q && w_have_q && !bvalid_q)
			begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= buck_seq_pkg::RESP_OKAY;
				case (awaddr_q)
					buck_seq_pkg::ADDR_CTRL:
					begin
						if (wstrb_q[0])
							ctrl_q <= wdata_q[2:0];
					end
					buck_seq_pkg::ADDR_EXTREF:
					begin
						if (wstrb_q[0])
							extref_q[7:0] <= wdata_q[7:0];
						if (wstrb_q[1])
							extref_q[11:8] <= wdata_q[11:8];
					end
					buck_seq_pkg::ADDR_STATUS: ;
					default:
						bresp_q <= buck_seq_pkg::RESP_SLVERR;
				endcase
			end
			else if (bvalid_q && s_axi_bready)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// --------------------------------
	// axi4-lite read path
	// --------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= buck_seq_pkg::RESP_OKAY;
		end
		else
		begin
			arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
			if (s_axi_arvalid && arready_q)
			begin
				rvalid_q <= 1'b1;
				rresp_q  <= buck_seq_pkg::RESP_OKAY;
				case (s_axi_araddr)
					buck_seq_pkg::ADDR_CTRL:   rdata_q <= {29'h0, ctrl_q};
					buck_seq_pkg::ADDR_EXTREF: rdata_q <= {20'h0, extref_q};
					buck_seq_pkg::ADDR_STATUS:
						rdata_q <= {13'h0000, ss_code_o, retry_q, uv_trip_q, latch_q,
							absent_q, ss_done_q, ref_ext_sel_o, state_q == buck_seq_pkg::ST_RUN};
					default:
					begin
						rdata_q <= 32'h0000_0000;
						rresp_q <= buck_seq_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (rvalid_q && s_axi_rready)
			begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// --------------------------------
	// soft-start ramp
	// --------------------------------
	ss_ramp_if   ramp ();
	logic        ramp_clear_q, ramp_run_q, ref_ext_q;
	logic [15:0] period_q;

	assign ramp.clear  = ramp_clear_q;
	assign ramp.run    = ramp_run_q;
	assign ramp.period = period_q;

	ss_ramp_gen u_ramp (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ramp    (ramp)
	);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			period_q <= buck_seq_pkg::STEP_FAST;
		else if (ref_variant && ref_ext_q)
			period_q <= ext_step(extref_q);
		else
			case (speed)
				buck_seq_pkg::SPD_MID:  period_q <= buck_seq_pkg::STEP_MID;
				buck_seq_pkg::SPD_SLOW: period_q <= buck_seq_pkg::STEP_SLOW;
				buck_seq_pkg::SPD_EXT:  period_q <= ext_step(extref_q);
				default:                period_q <= buck_seq_pkg::STEP_FAST;
			endcase
	end

	// --------------------------------
	// sequencer
	// --------------------------------
	logic [15:0] timer_q;
	logic [9:0]  uv_cnt_q;
	logic [2:0]  phase_cnt_q;
	logic        hs_seen_q, phase_chk_q, prebias_ok_q;
	logic        absent_evt, oc_evt, uv_evt;

	assign absent_evt = phase_chk_q && (phase_cnt_q == buck_seq_pkg::PHASE_CHK_CYC) && !phase_s;
	assign oc_evt     = oc_s && (state_q == buck_seq_pkg::ST_RAMP || state_q == buck_seq_pkg::ST_RUN);
	assign uv_evt     = (state_q == buck_seq_pkg::ST_RUN) && (uv_cnt_q == buck_seq_pkg::UV_CYCLES);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q      <= buck_seq_pkg::ST_OFF;
			timer_q      <= 16'h0000;
			ramp_clear_q <= 1'b1;
			ramp_run_q   <= 1'b0;
			ref_ext_q    <= 1'b0;
			retry_q      <= 3'h0;
			ss_done_q    <= 1'b0;
			latch_q      <= 1'b0;
			absent_q     <= 1'b0;
			uv_trip_q    <= 1'b0;
		end
		else if (!por_s)
		begin
			state_q      <= buck_seq_pkg::ST_OFF;
			ramp_clear_q <= 1'b1;
			ramp_run_q   <= 1'b0;
			ss_done_q    <= 1'b0;
			latch_q      <= 1'b0;
			retry_q      <= 3'h0;
		end
		else if (!en_s && state_q != buck_seq_pkg::ST_OFF)
		begin
			state_q      <= buck_seq_pkg::ST_IDLE;
			ramp_clear_q <= 1'b1;
			ramp_run_q   <= 1'b0;
			ss_done_q    <= 1'b0;
			latch_q      <= 1'b0;
			retry_q      <= 3'h0;
		end
		else
		begin
			ramp_clear_q <= 1'b0;
			case (state_q)
				buck_seq_pkg::ST_OFF:
					state_q <= buck_seq_pkg::ST_IDLE;
				buck_seq_pkg::ST_IDLE:
				begin
					timer_q    <= 16'h0000;
					absent_q   <= 1'b0;
					uv_trip_q  <= 1'b0;
					ramp_run_q <= ~ref_variant;
					state_q    <= ref_variant ? buck_seq_pkg::ST_REFSEL
						: buck_seq_pkg::ST_RAMP;
				end
				buck_seq_pkg::ST_REFSEL:
				begin
					timer_q <= timer_q + 16'h0001;
					if (timer_q + 16'h0001 >= REF_DELAY_W)
					begin
						ref_ext_q  <= ~reference_enable_pin_s;
						ramp_run_q <= 1'b1;
						state_q    <= buck_seq_pkg::ST_RAMP;
					end
				end
				buck_seq_pkg::ST_RAMP, buck_seq_pkg::ST_RUN:
				begin
					if (oc_evt)
					begin
						if (retry_q == buck_seq_pkg::OC_MAX_RETRY)
						begin
							latch_q <= 1'b1;
							state_q <= buck_seq_pkg::ST_LATCH;
						end
						else
						begin
							retry_q <= retry_q + 3'h1;
							state_q <= buck_seq_pkg::ST_HICCUP;
						end
						ss_done_q <= 1'b0;
						timer_q   <= 16'h0000;
					end
					else if (absent_evt || uv_evt)
					begin
						absent_q  <= absent_q | absent_evt;
						uv_trip_q <= uv_trip_q | uv_evt;
						ss_done_q <= 1'b0;
						timer_q   <= 16'h0000;
						state_q   <= buck_seq_pkg::ST_HICCUP;
					end
					else if (state_q == buck_seq_pkg::ST_RAMP && ramp.at_top && !ramp_clear_q)
					begin
						ss_done_q <= 1'b1;
						retry_q   <= 3'h0;
						state_q   <= buck_seq_pkg::ST_RUN;
					end
				end
				buck_seq_pkg::ST_HICCUP:
				begin
					if (ramp.at_top)
					begin
						timer_q <= timer_q + 16'h0001;
						if (timer_q + 16'h0001 >= HICCUP_W)
						begin
							ramp_clear_q <= 1'b1;
							state_q      <= buck_seq_pkg::ST_RAMP;
						end
					end
				end
				buck_seq_pkg::ST_LATCH:
					ramp_run_q <= 1'b0;
				default:
					state_q <= buck_seq_pkg::ST_OFF;
			endcase
		end
	end

	// --------------------------------
	// undervoltage qualification
	// --------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			uv_cnt_q <= 10'h000;
		else if (state_q != buck_seq_pkg::ST_RUN || !uv_s)
			uv_cnt_q <= 10'h000;
		else if (uv_cnt_q != buck_seq_pkg::UV_CYCLES)
			uv_cnt_q <= uv_cnt_q + 10'h001;
	end

	// --------------------------------
	// pre-bias and input detection
	// --------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prebias_ok_q <= 1'b0;
			hs_seen_q    <= 1'b0;
			phase_chk_q  <= 1'b0;
			phase_cnt_q  <= 3'h0;
		end
		else if (state_q != buck_seq_pkg::ST_RAMP && state_q != buck_seq_pkg::ST_RUN)
		begin
			prebias_ok_q <= 1'b0;
			hs_seen_q    <= 1'b0;
			phase_chk_q  <= 1'b0;
			phase_cnt_q  <= 3'h0;
		end
		else
		begin
			if (above_out_s && !out_high_s)
				prebias_ok_q <= 1'b1;
			if (high_side_drive_o && !hs_seen_q)
			begin
				hs_seen_q   <= 1'b1;
				phase_chk_q <= 1'b1;
			end
			if (phase_chk_q)
			begin
				phase_cnt_q <= phase_cnt_q + 3'h1;
				if (phase_cnt_q == buck_seq_pkg::PHASE_CHK_CYC)
					phase_chk_q <= 1'b0;
			end
		end
	end

	// --------------------------------
	// gate drives and analog controls
	// --------------------------------
	logic enabled;
	logic gates_ok;

	assign enabled  = state_q == buck_seq_pkg::ST_REFSEL || state_q == buck_seq_pkg::ST_RAMP
		|| state_q == buck_seq_pkg::ST_RUN || state_q == buck_seq_pkg::ST_HICCUP;
	assign gates_ok = (state_q == buck_seq_pkg::ST_RAMP || state_q == buck_seq_pkg::ST_RUN)
		&& prebias_ok_q && !oc_s && !absent_evt && !uv_evt;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			high_side_drive_o <= 1'b0;
			low_side_drive_o  <= 1'b0;
		end
		else if (enabled && ov_s)
		begin
			high_side_drive_o <= 1'b0;
			low_side_drive_o  <= 1'b1;
		end
		else if (gates_ok)
		begin
			high_side_drive_o <= pwm_s;
			low_side_drive_o  <= ~pwm_s;
		end
		else
		begin
			high_side_drive_o <= 1'b0;
			low_side_drive_o  <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			charge_src_en_o <= 1'b0;
		else if (state_q == buck_seq_pkg::ST_OFF || ref_variant)
			charge_src_en_o <= 1'b0;
		else if (state_q == buck_seq_pkg::ST_RUN)
			charge_src_en_o <= charge_src_en_o && !comp_ceil_s;
		else
			charge_src_en_o <= 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			target_code_o <= 10'h000;
		else if (ramp.code < buck_seq_pkg::REF_CODE)
			target_code_o <= ramp.code;
		else
			target_code_o <= buck_seq_pkg::REF_CODE;
	end

	assign ref_ext_sel_o = ref_ext_q;
	assign ss_code_o     = ramp.code;
	assign ss_done_o     = ss_done_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
endmodule : buck_startup_seq

// file: shared/buck_seq_pkg.sv
/*
 * constants, register map and state encodings for the buck start-up sequencer.
 * assumes a 25 MHz system clock; all times convert to cycles of that clock.
 */
package buck_seq_pkg;
	localparam int          CLK_NS        = 40;
	localparam int          SS_STEPS      = 100;
	localparam logic [9:0]  REF_CODE      = 10'h064;
	localparam logic [9:0]  CEIL_CODE     = 10'h2BC;
	localparam int          RAMP_FAST_US  = 2000;
	localparam int          RAMP_MID_US   = 2600;
	localparam int          RAMP_SLOW_US  = 3600;
	localparam logic [15:0] STEP_FAST     = 16'((RAMP_FAST_US * 1000 / CLK_NS) / SS_STEPS);
	localparam logic [15:0] STEP_MID      = 16'((RAMP_MID_US * 1000 / CLK_NS) / SS_STEPS);
	localparam logic [15:0] STEP_SLOW     = 16'((RAMP_SLOW_US * 1000 / CLK_NS) / SS_STEPS);
	localparam int          EXT_FACTOR_X10 = 25;
	localparam int          UV_DELAY_NS   = 15000;
	localparam logic [9:0]  UV_CYCLES     = 10'((UV_DELAY_NS + CLK_NS - 1) / CLK_NS);
	localparam int          REF_DELAY_US  = 1000;
	localparam int          HICCUP_US     = 1000;
	localparam int          REF_DELAY_CYC = REF_DELAY_US * 1000 / CLK_NS;
	localparam int          HICCUP_CYC    = HICCUP_US * 1000 / CLK_NS;
	localparam logic [2:0]  OC_MAX_RETRY  = 3'h4;
	localparam logic [2:0]  PHASE_CHK_CYC = 3'h4;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_EXTREF   = 8'h04;
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;
	localparam logic [2:0]  CTRL_RST      = 3'h0;
	localparam logic [11:0] EXTREF_RST    = 12'h3E8;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,
		ST_IDLE   = 3'b001,
		ST_REFSEL = 3'b010,
		ST_RAMP   = 3'b011,
		ST_RUN    = 3'b100,
		ST_HICCUP = 3'b101,
		ST_LATCH  = 3'b110
	} state_t;

	typedef enum logic [1:0] {
		SPD_FAST = 2'b00,
		SPD_MID  = 2'b01,
		SPD_SLOW = 2'b10,
		SPD_EXT  = 2'b11
	} speed_t;
endpackage : buck_seq_pkg

// file: shared/ss_ramp_if.sv
/*
 * link between the sequencer core and the soft-start staircase generator.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface ss_ramp_if;
	logic        clear;
	logic        run;
	logic [15:0] period;
	logic [9:0]  code;
	logic        at_top;
	modport ctrl (output clear, output run, output period, input code, input at_top);
	modport gen  (input clear, input run, input period, output code, output at_top);
endinterface : ss_ramp_if

// file: rtl/ss_ramp_gen.sv
/*
 * soft-start staircase: one code step per period, up to the ceiling code.
 * assumes period is stable while run is high.
 */
`timescale 1ns/1ps
module ss_ramp_gen (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ss_ramp_if.gen    ramp
);
	logic [15:0] tick_q;
	logic [9:0]  code_q;

	assign ramp.code   = code_q;
	assign ramp.at_top = (code_q == buck_seq_pkg::CEIL_CODE);

	// --------------------------------
	// staircase counter
	// --------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tick_q <= 16'h0000;
			code_q <= 10'h000;
		end
		else if (ramp.clear)
		begin
			tick_q <= 16'h0000;
			code_q <= 10'h000;
		end
		else if (ramp.run && !ramp.at_top)
		begin
			if (tick_q + 16'h0001 >= ramp.period)
			begin
				tick_q <= 16'h0000;
				code_q <= code_q + 10'h001;
			end
			else
			begin
				tick_q <= tick_q + 16'h0001;
			end
		end
	end
endmodule : ss_ramp_gen

// file: bench/power_stage_model.sv
/*
 * switch-node model of the external two-switch power stage.
 * assumes gate enables from the sequencer and a supply flag from the bench.
 */
`timescale 1ns/1ps
// ----------------
// power stage
// ----------------
module power_stage_model (
	input  wire logic high_i,
	input  wire logic low_i,
	input  wire logic vin_on_i,
	output logic      phase_high_o
);
	// node rises only with high side on and supply present, else pulled low
	assign phase_high_o = high_i & vin_on_i & ~low_i;
endmodule : power_stage_model

// file: bench/buck_seq_props.sv
/*
 * assertions on the ports of the buck start-up sequencer.
 * assumes binding into buck_startup_seq, one clock, reset active low.
 */
`timescale 1ns/1ps
module buck_seq_props (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       comp_ceiling_i,
	input  wire logic       overcurrent_i,
	input  wire logic       overvoltage_i,
	input  wire logic       undervoltage_i,
	input  wire logic       high_side_drive_o,
	input  wire logic       low_side_drive_o,
	input  wire logic       charge_src_en_o,
	input  wire logic       ss_done_o,
	input  wire logic [9:0] ss_code_o,
	input  wire logic [9:0] target_code_o
);
	// ----------------
	// checks
	// ----------------
	logic [9:0] uv_run_q;
	logic [9:0] min_code;
	assign min_code = (ss_code_o > buck_seq_pkg::REF_CODE) ? buck_seq_pkg::REF_CODE : ss_code_o;
	// cycles of undervoltage while armed
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			uv_run_q <= 10'h000;
		else
			uv_run_q <= (undervoltage_i && ss_done_o) ? uv_run_q + {9'h000, ~&uv_run_q} : 10'h000;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	gates_exclusive_a: assert property (!(high_side_drive_o && low_side_drive_o))
		else $error("both gates on");
	ov_high_off_a: assert property (overvoltage_i [*5] |-> !high_side_drive_o)
		else $error("high side on in overvoltage");
	oc_gates_off_a: assert property ((overcurrent_i && !overvoltage_i) [*5] |->
		!high_side_drive_o && !low_side_drive_o) else $error("gate on in overcurrent");
	done_at_ceiling_a: assert property ($rose(ss_done_o) |-> ss_code_o == 10'h2BC)
		else $error("done before ceiling");
	target_min_a: assert property ($stable(ss_code_o) [*3] |-> target_code_o == min_code)
		else $error("target not lower of ramp and reference");
	ramp_step_a: assert property ($changed(ss_code_o) |->
		ss_code_o == $past(ss_code_o) + 10'h001 || ss_code_o == 10'h000) else $error("ramp jump");
	charge_off_a: assert property ((ss_done_o && comp_ceiling_i) [*5] |-> !charge_src_en_o)
		else $error("charge source on above ceiling");
	uv_qualify_a: assert property (uv_run_q < 10'h186)
		else $error("undervoltage not acted on");
endmodule : buck_seq_props
bind buck_startup_seq buck_seq_props buck_seq_props_inst (.*);

// file: bench/tb.sv
/*
 * self-checking bench for the buck start-up sequencer.
 * assumes the bound checker and the power stage model on the gate enables.
 */
`timescale 1ns/1ps
module tb;
	// ----------------
	// bench
	// ----------------
	logic        clk_i, rst_n_i, por_ok_i, enable_above_i, comp_ceiling_i, phase_high_i;
	logic        reference_enable_pin_high_i, overcurrent_i, overvoltage_i, undervoltage_i;
	logic        ramp_above_out_i, out_above_target_i, pwm_high_i, vin_on;
	logic        high_side_drive_o, low_side_drive_o, charge_src_en_o, ref_ext_sel_o, ss_done_o;
	logic [9:0]  ss_code_o, target_code_o;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, gates;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          fails = 0, total_checks = 0, n;
	assign gates = {high_side_drive_o, low_side_drive_o};
	buck_startup_seq #(.REF_DELAY(20), .HICCUP(20)) buck_startup_seq_inst (.*);
	power_stage_model power_stage_model_inst (.high_i(high_side_drive_o),
		.low_i(low_side_drive_o), .vin_on_i(vin_on), .phase_high_o(phase_high_i));
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task tally_and_finish;
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask : cyc
	// waits for ramp code (sel 1) or done flag (sel 0), n holds the edges
	task wait_for(input logic sel, input logic [9:0] v, input int lim);
		n = 0;
		while ((sel ? ss_code_o : {9'h000, ss_done_o}) !== v && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("wait", 32'(v), sel ? 32'(ss_code_o) : 32'(ss_done_o));
	endtask : wait_for
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task t_regs;
		axi_rd(8'h04);
		chk("extref", {20'h0, buck_seq_pkg::EXTREF_RST}, rd);
		axi_rd(8'h0C);
		chk("resp", {30'h0, buck_seq_pkg::RESP_SLVERR}, {30'h0, rs});
		chk("rdata", 32'h0, rd);
		axi_wr(8'h04, 32'h8);
		axi_wr(8'h00, 32'h6);
		axi_rd(8'h00);
		chk("ctrl", 32'h6, rd);
	endtask : t_regs
	task t_start;
		enable_above_i <= 1'b1;
		cyc(50);
		chk("code", 32'h0, 32'(ss_code_o));
		por_ok_i <= 1'b1;
		wait_for(1'b1, 10'h00A, 400);
		wait_for(1'b1, 10'h00B, 50);
		chk("step", 32'h5, n);
		chk("gates", 32'h0, 32'(gates));
		{ramp_above_out_i, out_above_target_i} <= 2'h3;
		cyc(8);
		chk("gates", 32'h0, 32'(gates));
		out_above_target_i <= 1'b0;
		cyc(8);
		chk("gates", 32'h2, 32'(gates));
		wait_for(1'b0, 10'h001, 4000);
		chk("code", 32'h2BC, 32'(ss_code_o));
		chk("target", 32'h64, 32'(target_code_o));
	endtask : t_start
	task t_ov;
		overvoltage_i <= 1'b1;
		cyc(6);
		chk("gates", 32'h1, 32'(gates));
		overvoltage_i <= 1'b0;
		cyc(6);
		chk("gates", 32'h2, 32'(gates));
		pwm_high_i <= 1'b0;
		cyc(6);
		chk("gates", 32'h1, 32'(gates));
		pwm_high_i <= 1'b1;
		cyc(6);
		chk("charge", 32'h1, 32'(charge_src_en_o));
		comp_ceiling_i <= 1'b1;
		cyc(6);
		chk("charge", 32'h0, 32'(charge_src_en_o));
	endtask : t_ov
	task t_uv;
		undervoltage_i <= 1'b1;
		cyc(300);
		undervoltage_i <= 1'b0;
		cyc(6);
		chk("done", 32'h1, 32'(ss_done_o));
		undervoltage_i <= 1'b1;
		cyc(370);
		chk("done", 32'h1, 32'(ss_done_o));
		wait_for(1'b0, 10'h000, 30);
		cyc(2);
		chk("gates", 32'h0, 32'(gates));
		undervoltage_i <= 1'b0;
		wait_for(1'b0, 10'h001, 8000);
	endtask : t_uv
	task t_oc;
		overcurrent_i <= 1'b1;
		cyc(6);
		chk("gates", 32'h0, 32'(gates));
		overcurrent_i <= 1'b0;
		wait_for(1'b0, 10'h001, 8000);
		axi_rd(8'h08);
		chk("retries", 32'h0, 32'(rd[8:6]));
		overcurrent_i <= 1'b1;
		cyc(6);
		chk("gates", 32'h0, 32'(gates));
		rd = 32'h0;
		for (n = 0; n < 300 && !rd[4]; n++)
		begin
			cyc(100);
			axi_rd(8'h08);
		end
		overcurrent_i <= 1'b0;
		chk("latch", 32'h1, 32'(rd[4]));
		chk("retries", 32'h4, 32'(rd[8:6]));
		cyc(50);
		chk("gates", 32'h0, 32'(gates));
		enable_above_i <= 1'b0;
		cyc(6);
		axi_rd(8'h08);
		chk("latch", 32'h0, 32'(rd[4]));
	endtask : t_oc
	task t_vin;
		vin_on <= 1'b0;
		enable_above_i <= 1'b1;
		wait_for(1'b1, 10'h03C, 800);
		axi_rd(8'h08);
		chk("absent", 32'h1, 32'(rd[3]));
		chk("gates", 32'h0, 32'(gates));
		wait_for(1'b1, 10'h2BC, 4000);
		chk("done", 32'h0, 32'(ss_done_o));
		vin_on <= 1'b1;
		wait_for(1'b0, 10'h001, 8000);
		axi_rd(8'h08);
		chk("retries", 32'h0, 32'(rd[8:6]));
	endtask : t_vin
	task t_ref;
		for (n = 0; n < 2; n++)
		begin
			enable_above_i <= 1'b0;
			cyc(6);
			axi_wr(8'h00, 32'h7);
			reference_enable_pin_high_i <= n[0];
			enable_above_i <= 1'b1;
			cyc(12);
			chk("code", 32'h0, 32'(ss_code_o));
			cyc(30);
			chk("ref ext", {31'h0, ~n[0]}, 32'(ref_ext_sel_o));
		end
		enable_above_i <= 1'b0;
		cyc(6);
		axi_wr(8'h00, 32'h0);
		enable_above_i <= 1'b1;
		wait_for(1'b1, 10'h001, 600);
		wait_for(1'b1, 10'h002, 600);
		chk("step", 32'(buck_seq_pkg::STEP_FAST), n);
	endtask : t_ref
	initial
	begin
		{rst_n_i, por_ok_i, enable_above_i, comp_ceiling_i, reference_enable_pin_high_i} = '0;
		{overcurrent_i, overvoltage_i, undervoltage_i, ramp_above_out_i, out_above_target_i} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, pwm_high_i, vin_on} = 5'h03;
		s_axi_wstrb = 4'hF;
		cyc(20);
		rst_n_i <= 1'b1;
		t_regs;
		t_start;
		t_ov;
		t_uv;
		t_oc;
		t_vin;
		t_ref;
		tally_and_finish;
	end
	initial
	begin
		repeat (100000) @(posedge clk_i);
		fails++;
		tally_and_finish;
	end
endmodule : tb
